// ### core/explicit_tx_parser.sv
`timescale 1ns/1ps
// What this block does
// - Type byte at offset 3 must be 0x11
// - Keep identifier, echo in status frame 0x8b
// - Zero identifier suppresses the status frame
// - Own hardware address match, else IPv4
// - Endpoint at 16, cluster at 17-18
// - Options bit 0x01 disables acknowledgement
// - Payload from 23, up to 1392 bytes
module explicit_tx_parser
  import tx_frame_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Own identity
  input wire logic [47:0] ownHwAddr,
  // Serial byte stream in
  input wire logic [7:0] inByte,
  input wire logic inValid,
  output logic inReady,
  // Payload bytes out
  output logic [7:0] payByte,
  output logic payValid,
  input wire logic payReady,
  // Decoded request; reqDone or reqBad pulses once after the checksum byte
  output logic reqDone,
  output logic reqBad,
  output logic [7:0] reqId,
  output logic [63:0] reqAddr,
  output logic reqIsHwAddr,
  output logic [7:0] reqEndpoint,
  output logic [15:0] reqCluster,
  output logic reqNoAck,
  output logic [10:0] reqPayLen,
  output logic statusReq,
  output logic [7:0] statusType
);
  import tx_frame_pkg::*;

  typedef enum {S_DELIM, S_LENHI, S_LENLO, S_BODY, S_SUM} state_e;
  state_e state_reg, state_next;

  logic [15:0] len_reg;
  logic [15:0] pos_reg;
  logic [7:0] sum_reg;
  logic [7:0] type_reg;
  logic [7:0] id_reg;
  logic [63:0] addr_reg;
  logic [7:0] ep_reg;
  logic [15:0] cl_reg;
  logic [7:0] opt_reg;
  logic [10:0] payCnt_reg;
  logic [7:0] buf0_reg, buf1_reg;
  logic [1:0] fill_reg;
  logic done_reg, bad_reg, stat_reg;

  // Two-entry skid buffer on the payload path
  wire bufFull = (fill_reg == 2'd2);
  wire inFire = inValid && inReady;
  wire outFire = payValid && payReady;
  wire atBody = (state_reg == S_BODY);
  wire [15:0] ofs = pos_reg;
  wire lastBody = atBody && (pos_reg == len_reg + 16'd2);
  wire isPayload = atBody && (ofs >= 16'(OFS_PAYLOAD));
  wire payFits = (payCnt_reg < 11'(MAX_PAYLOAD));
  wire pushPay = inFire && isPayload && payFits
                 && (type_reg == TYPE_EXPLICIT_TX);
  wire [7:0] sumNext = sum_reg + inByte;
  wire sumOk = (sumNext == CHECKSUM_GOOD);
  wire typeOk = (type_reg == TYPE_EXPLICIT_TX);
  wire lenOk = (len_reg >= HEADER_LEN) && (len_reg <= MAX_LEN);
  wire goodFrame = sumOk && typeOk;
  // Low six bytes compared with own address
  wire hwMatch = (addr_reg[8*HW_ADDR_BYTES-1:0] == ownHwAddr);

  // Fill after this edge; both handshakes leave flip-flops
  wire [1:0] fillNext = fill_reg + {1'b0, pushPay} - {1'b0, outFire};
  assign payByte = buf0_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_DELIM: if (inFire && inByte == START_DELIM) state_next = S_LENHI;
      S_LENHI: if (inFire) state_next = S_LENLO;
      S_LENLO: if (inFire) state_next = S_BODY;
      S_BODY: if (inFire && lastBody) state_next = S_SUM;
      S_SUM: if (inFire) state_next = S_DELIM;
      default: state_next = S_DELIM;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) state_reg <= S_DELIM;
    else state_reg <= state_next;
  end

  // Length and position tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      len_reg <= 16'h0000;
      pos_reg <= 16'h0000;
      sum_reg <= 8'h00;
    end else if (inFire) begin
      pos_reg <= (state_reg == S_DELIM) ? 16'd1 : pos_reg + 16'd1;
      if (state_reg == S_LENHI) len_reg[15:8] <= inByte;
      if (state_reg == S_LENLO) len_reg[7:0] <= inByte;
      if (state_reg == S_LENLO) begin
        if (inByte == 8'h00 && len_reg[15:8] == 8'h00) begin
          len_reg <= 16'h0001;
        end
      end
      sum_reg <= atBody ? sumNext : 8'h00;
    end
  end

  // Field capture; reserved bytes never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      type_reg <= 8'h00;
      id_reg <= 8'h00;
      addr_reg <= 64'h0;
      ep_reg <= 8'h00;
      cl_reg <= 16'h0000;
      opt_reg <= 8'h00;
    end else if (inFire && atBody) begin
      if (ofs == 16'(OFS_TYPE)) type_reg <= inByte;
      if (ofs == 16'(OFS_ID)) id_reg <= inByte;
      if (ofs >= 16'(OFS_ADDR_FIRST) && ofs <= 16'(OFS_ADDR_LAST)) begin
        addr_reg <= {addr_reg[55:0], inByte};
      end
      if (ofs == 16'(OFS_ENDPOINT)) ep_reg <= inByte;
      if (ofs == 16'(OFS_CLUSTER_HI)) cl_reg[15:8] <= inByte;
      if (ofs == 16'(OFS_CLUSTER_LO)) cl_reg[7:0] <= inByte;
      if (ofs == 16'(OFS_OPTIONS)) opt_reg <= inByte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) payCnt_reg <= 11'd0;
    else if (state_reg == S_DELIM) payCnt_reg <= 11'd0;
    else if (pushPay) payCnt_reg <= payCnt_reg + 11'd1;
  end

  // Buffer: entry 0 is the head
  // Ready drops on full even for header bytes: shorter path
  always_ff @(posedge clk) begin
    if (rst) begin
      fill_reg <= 2'd0;
      buf0_reg <= 8'h00;
      buf1_reg <= 8'h00;
      inReady <= 1'b1;
      payValid <= 1'b0;
    end else begin
      inReady <= (fillNext != 2'h2);
      payValid <= (fillNext != 2'h0);
      case ({pushPay, outFire})
        2'b10: begin
          if (fill_reg == 2'd0) buf0_reg <= inByte;
          else buf1_reg <= inByte;
          fill_reg <= fill_reg + 2'd1;
        end
        2'b01: begin
          buf0_reg <= buf1_reg;
          fill_reg <= fill_reg - 2'd1;
        end
        2'b11: begin
          if (fill_reg == 2'd1) buf0_reg <= inByte;
          else begin
            buf0_reg <= buf1_reg;
            buf1_reg <= inByte;
          end
        end
        default: fill_reg <= fill_reg;
      endcase
    end
  end

  wire endFrame = inFire && (state_reg == S_SUM);

  // Results are published only after the checksum
  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
      bad_reg <= 1'b0;
      stat_reg <= 1'b0;
      reqId <= 8'h00;
      reqAddr <= 64'h0;
      reqIsHwAddr <= 1'b0;
      reqEndpoint <= 8'h00;
      reqCluster <= 16'h0000;
      reqNoAck <= 1'b0;
      reqPayLen <= 11'd0;
      statusType <= TYPE_TX_STATUS;
    end else begin
      done_reg <= endFrame && goodFrame && lenOk;
      bad_reg <= endFrame && !(goodFrame && lenOk);
      stat_reg <= endFrame && goodFrame && lenOk
                  && (id_reg != 8'h00);
      if (endFrame && goodFrame && lenOk) begin
        reqId <= id_reg;
        reqAddr <= addr_reg;
        reqIsHwAddr <= hwMatch;
        reqEndpoint <= ep_reg;
        reqCluster <= cl_reg;
        reqNoAck <= (opt_reg & OPT_DISABLE_ACK) != 8'h00;
        reqPayLen <= payCnt_reg;
      end
    end
  end

  assign reqDone = done_reg;
  assign reqBad = bad_reg;
  assign statusReq = stat_reg;

  AST_STATUS_ZERO_ID: assert property (@(posedge clk) disable iff (rst)
    statusReq |-> reqId != 8'h00 && reqDone)
    else $error("status requested for zero identifier");
  AST_DONE_AFTER_SUM: assert property (@(posedge clk) disable iff (rst)
    reqDone |-> $past(state_reg == S_SUM) && $past(inFire))
    else $error("request done without checksum byte");
  AST_STATUS_ECHO: assert property (@(posedge clk) disable iff (rst)
    statusReq |-> reqId == $past(id_reg))
    else $error("status identifier not echoed");
  AST_TYPE_OK: assert property (@(posedge clk) disable iff (rst)
    reqDone |-> $past(type_reg) == TYPE_EXPLICIT_TX)
    else $error("wrong frame type accepted");
  AST_PAY_LIMIT: assert property (@(posedge clk) disable iff (rst)
    payCnt_reg <= 11'(MAX_PAYLOAD))
    else $error("payload count over limit");
  AST_NOACK: assert property (@(posedge clk) disable iff (rst)
    reqDone |-> reqNoAck == $past(opt_reg[0]))
    else $error("ack option not decoded");
  AST_HWADDR: assert property (@(posedge clk) disable iff (rst)
    reqDone |-> reqIsHwAddr == $past(hwMatch))
    else $error("hardware address match wrong");
  AST_CLUSTER: assert property (@(posedge clk) disable iff (rst)
    reqDone |-> reqCluster == $past(cl_reg)
                && reqEndpoint == $past(ep_reg))
    else $error("endpoint or cluster wrong");
  AST_NO_OVERFLOW: assert property (@(posedge clk) disable iff (rst)
    bufFull && !payReady |=> fill_reg == 2'd2)
    else $error("buffer lost a word");
  COV_STATUS: cover property (@(posedge clk) statusReq);
  COV_SILENT: cover property (@(posedge clk) reqDone && !statusReq);
  COV_BAD: cover property (@(posedge clk) reqBad);
  COV_STALL: cover property (@(posedge clk) bufFull && !inReady);
endmodule

// ### inc/tx_frame_pkg.sv
package tx_frame_pkg;
  localparam logic [7:0] START_DELIM = 8'h7e;
  localparam logic [7:0] TYPE_EXPLICIT_TX = 8'h11;
  localparam logic [7:0] TYPE_TX_STATUS = 8'h8b;
  localparam logic [7:0] OPT_DISABLE_ACK = 8'h01;
  localparam logic [7:0] CHECKSUM_GOOD = 8'hff;
  // Offsets into the frame data, counted from the start delimiter
  localparam int OFS_TYPE = 3;
  localparam int OFS_ID = 4;
  localparam int OFS_ADDR_FIRST = 5;
  localparam int OFS_ADDR_LAST = 12;
  localparam int OFS_ENDPOINT = 16;
  localparam int OFS_CLUSTER_HI = 17;
  localparam int OFS_CLUSTER_LO = 18;
  localparam int OFS_OPTIONS = 22;
  localparam int OFS_PAYLOAD = 23;
  localparam int MAX_PAYLOAD = 1392;
  localparam int HW_ADDR_BYTES = 6;
  localparam logic [15:0] HEADER_LEN = 16'h0014;
  localparam logic [15:0] MAX_LEN = 16'h0584;
  localparam int CNT_W = 11;
  localparam logic [47:0] OWN_HW_ADDR_DEFAULT = 48'h0000_0000_0001;
endpackage

// ### sim/frame_host.sv
`timescale 1ns/1ps
module frame_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Byte stream
  output logic [7:0] inByte,
  output logic inValid,
  input wire logic inReady
);
  logic [7:0] txq[$];
  int gap = 0;
  int waited = 0;
  bit taken;
  initial begin
    inByte = 8'h00;
    inValid = 1'b0;
  end
  // Delimiter, length, body, checksum
  task automatic send(input logic [7:0] ftype, id, input logic [63:0] addr,
    input logic [7:0] ep, input logic [15:0] cl, input logic [7:0] opt,
    input int n, input bit badSum);
    logic [7:0] body[$];
    logic [7:0] sum;
    body = {ftype, id};
    for (int i = 7; i >= 0; i--) body.push_back(addr[i*8 +: 8]);
    body = {body, 8'hff, 8'hfe, 8'he6, ep, cl[15:8], cl[7:0]};
    body = {body, 8'hc1, 8'h05, 8'h00, opt};
    for (int i = 0; i < n; i++) body.push_back(8'(i * 7 + 3));
    sum = 8'h00;
    foreach (body[i]) sum += body[i];
    txq = {txq, 8'h7e, 8'(body.size() >> 8), 8'(body.size()), body};
    txq.push_back((8'hff - sum) ^ {7'h00, badSum});
  endtask
  always @(posedge clk) begin
    taken = inValid && inReady;
    #1;
    if (taken || !inValid) begin
      if (!rst && txq.size() > 0 && waited >= gap) begin
        inByte = txq.pop_front();
        inValid = 1'b1;
        waited = 0;
      end else begin
        // Idle line inverts inByte each cycle, so the stale byte returns every second idle cycle
        inByte = ~inByte;
        inValid = 1'b0;
        waited++;
      end
    end
  end
endmodule

// ### sim/test_explicit_transmit_frame_parser.sv
`timescale 1ns/1ps
module test_explicit_transmit_frame_parser;
  import tx_frame_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic payReady = 1'b1;
  logic [47:0] ownHwAddr = 48'h0a1b_2c3d_4e5f;
  logic [7:0] inByte, payByte, reqId, reqEndpoint, statusType;
  logic inValid, inReady, payValid, reqDone, reqBad, reqIsHwAddr;
  logic reqNoAck, statusReq;
  logic [63:0] reqAddr;
  logic [15:0] reqCluster;
  logic [10:0] reqPayLen;
  int miscompares = 0, samples_checked = 0;
  int doneCnt = 0, badCnt = 0, statCnt = 0, stalls = 0;
  logic [7:0] got[$];
  always #12.5 clk = ~clk;
  explicit_tx_parser u_explicit_tx_parser (.clk(clk), .rst(rst),
    .ownHwAddr(ownHwAddr), .inByte(inByte), .inValid(inValid),
    .inReady(inReady), .payByte(payByte), .payValid(payValid),
    .payReady(payReady), .reqDone(reqDone), .reqBad(reqBad), .reqId(reqId),
    .reqAddr(reqAddr), .reqIsHwAddr(reqIsHwAddr), .reqEndpoint(reqEndpoint),
    .reqCluster(reqCluster), .reqNoAck(reqNoAck), .reqPayLen(reqPayLen),
    .statusReq(statusReq), .statusType(statusType));
  frame_host u_frame_host (.clk(clk), .rst(rst), .inByte(inByte),
    .inValid(inValid), .inReady(inReady));
  always @(posedge clk) begin
    if (payValid === 1'b1 && payReady === 1'b1) got.push_back(payByte);
    if (reqDone === 1'b1) doneCnt++;
    if (reqBad === 1'b1) badCnt++;
    if (statusReq === 1'b1) statCnt++;
    if (inValid === 1'b1 && inReady === 1'b0) stalls++;
  end
  task automatic check(input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_frame();
    int n;
    n = doneCnt + badCnt;
    for (int i = 0; i < 4000 && doneCnt + badCnt == n; i++) @(posedge clk);
    if (doneCnt + badCnt == n) begin
      miscompares++;
      complete_run();
    end else begin
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // Receiver stalls until the buffer refuses, then drains
  task automatic good_frame();
    payReady = 1'b0;
    got.delete();
    u_frame_host.send(8'h11, 8'h5a, 64'h0000_0000_c0a8_0182, 8'he6,
      16'h0023, 8'h00, 8, 1'b0);
    repeat (40) @(posedge clk);
    #1 check(got.size(), 0);
    check(stalls > 0, 1);
    payReady = 1'b1;
    wait_frame();
    check({doneCnt, statCnt}, {32'd1, 32'd1});
    check({reqId, statusType}, {8'h5a, 8'h8b});
    check(reqAddr, 64'h0000_0000_c0a8_0182);
    check(reqIsHwAddr, 1'b0);
    check({reqEndpoint, reqCluster}, 24'he6_0023);
    check(reqNoAck, 1'b0);
    check({reqPayLen, 32'(got.size())}, {11'd8, 32'd8});
    foreach (got[i]) check(got[i], 8'(i * 7 + 3));
  endtask
  // Slow host, zero identifier, own address then one bit off
  task automatic hw_match();
    u_frame_host.gap = 2;
    for (int k = 0; k < 2; k++) begin
      u_frame_host.send(8'h11, 8'h00, {16'h0000, ownHwAddr ^ 48'(k)},
        8'he6, 16'h0023, 8'h01, 0, 1'b0);
      wait_frame();
      check({doneCnt, statCnt}, {32'(2 + k), 32'd1});
      check(reqIsHwAddr, k == 0);
      check({reqId, reqPayLen}, 19'h0);
      check(reqNoAck, 1'b1);
    end
    u_frame_host.gap = 0;
  endtask
  // Bad checksum then wrong type, back to back
  task automatic bad_frames();
    u_frame_host.send(8'h11, 8'h33, 64'h0, 8'he6, 16'h0023, 8'h00, 2, 1'b1);
    u_frame_host.send(8'h10, 8'h44, 64'h0, 8'he6, 16'h0023, 8'h00, 2, 1'b0);
    wait_frame();
    wait_frame();
    check({badCnt, doneCnt, statCnt}, {32'd2, 32'd3, 32'd1});
    check(reqId, 8'h00);
  endtask
  task automatic max_payload();
    got.delete();
    u_frame_host.send(8'h11, 8'h77, 64'h0, 8'he6, 16'h0023, 8'h00, 1392,
      1'b0);
    wait_frame();
    check({reqPayLen, 32'(got.size())}, {11'd1392, 32'd1392});
    check(got[1391], 8'(1391 * 7 + 3));
    check({doneCnt, statCnt}, {32'd4, 32'd2});
  endtask
  task automatic complete_run();
    $display("miscompares %0d samples_checked %0d", miscompares,
      samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    good_frame();
    hw_match();
    bad_frames();
    max_payload();
    complete_run();
  end
  // Whole run needs about 2000 cycles
  initial begin
    #500us;
    miscompares++;
    complete_run();
  end
endmodule
